/* core/cdsc_top.sv */
// clock divider, oscillator trim, sleep gating and wake sequencing
// assumes cpu i/o strobes are one cycle wide and synchronous to clk_i
`timescale 1ns/1ps
`include "cdsc_params.svh"
module cdsc_top
   import cdsc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic [7:0] io_addr_i,
   input  wire logic       io_data_space_i,
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   input  wire logic [7:0] io_wdata_i,
   output logic      [7:0] io_rdata_o,
   input  wire logic [7:0] cal_byte_i,
   input  wire logic       sleep_instr_i,
   input  wire logic       xtal_selected_i,
   input  wire logic       timer0_async_select_i,
   input  wire logic       any_irq_i,
   input  wire logic [3:0] edge_irq_low_i,
   input  wire logic [3:0] level_irq_high_i,
   input  wire logic       two_wire_unit_match_i,
   input  wire logic       timer0_irq_i,
   input  wire logic       conv_irq_i,
   input  wire logic       nvm_ready_irq_i,
   output logic      [7:0] trim_value_o,
   output logic            core_clk_en_o,
   output logic            nvm_clk_en_o,
   output logic            periph_clk_en_o,
   output logic            conv_clk_en_o,
   output logic            async_clk_en_o,
   output logic            main_osc_en_o,
   output logic            sleeping_o,
   output logic            wake_irq_o
);

   //////////////////////////////
   // functions

   // i/o address of an access, either form
   function automatic logic [7:0] io_offset(
      input logic [7:0] addr,
      input logic       data_space
   );
      logic [7:0] off;
      off = data_space ? 8'(addr - `CDSC_DS_OFFSET) : addr; // see (R7)
      return off;
   endfunction : io_offset

   function automatic logic io_in_range(
      input logic [7:0] addr,
      input logic       data_space
   );
      logic ok;
      if (data_space) begin
         ok = (addr >= `CDSC_DS_OFFSET) &&
              (addr <= 8'(`CDSC_IO_TOP + `CDSC_DS_OFFSET)); // see (R7)
      end else begin
         ok = (addr <= `CDSC_IO_TOP); // see (R7)
      end
      return ok;
   endfunction : io_in_range

   //////////////////////////////
   // registers

   logic        div_enable;
   logic [6:0]  divide_factor;
   logic [7:0]  osc_trim;
   logic        sleep_allow;
   logic [2:0]  sleep_select;
   logic        trim_load_pend;
   logic [7:0]  rdata;

   //////////////////////////////
   // address decode

   logic [7:0]  acc_off;
   logic        acc_ok;
   logic        sel_div;
   logic        sel_trim;
   logic        sel_mcu;
   logic        wr_div;
   logic        wr_trim;
   logic        wr_mcu;
   logic        wr_en_bit;
   logic        take_factor;

   assign acc_off  = io_offset(io_addr_i, io_data_space_i);
   assign acc_ok   = io_in_range(io_addr_i, io_data_space_i);
   assign sel_div  = acc_ok && (acc_off == `CDSC_ADDR_DIV);
   assign sel_trim = acc_ok && (acc_off == `CDSC_ADDR_TRIM);
   assign sel_mcu  = acc_ok && (acc_off == `CDSC_ADDR_MCUCTL);
   assign wr_div   = io_wr_i && sel_div;
   assign wr_trim  = io_wr_i && sel_trim;
   assign wr_mcu   = io_wr_i && sel_mcu;

   assign wr_en_bit = io_wdata_i[`CDSC_DIV_EN_BIT];

   // factor only taken by a write that turns division on from off
   assign take_factor = wr_div && wr_en_bit && !div_enable; // see (R3) (R4)

   //////////////////////////////
   // divider register

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_enable <= 1'(`CDSC_RST_DIV >> `CDSC_DIV_EN_BIT); // see (R24)
      end else if (wr_div) begin
         div_enable <= wr_en_bit; // see (R1)
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         divide_factor <= 7'(`CDSC_RST_DIV); // see (R24)
      end else if (take_factor) begin
         divide_factor <= io_wdata_i[6:0]; // see (R4)
      end
   end
   // a write with enable zero leaves the factor alone, see (R5)

   //////////////////////////////
   // oscillator trim

   // the calibration byte cannot enter under async reset, so it is loaded
   // on the first edge after release, where it wins over a trim register write
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trim_load_pend <= 1'b1;
      end else begin
         trim_load_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         osc_trim <= `CDSC_RST_TRIM;
      end else if (trim_load_pend) begin
         osc_trim <= cal_byte_i; // see (R8)
      end else if (wr_trim) begin
         osc_trim <= io_wdata_i;
      end
   end

   // straight binary code, so the analog trim rises monotonically
   assign trim_value_o = osc_trim; // see (R9) (R10)

   //////////////////////////////
   // mcu control bits

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sleep_allow  <= 1'b0; // see (R24)
         sleep_select <= 3'b000; // see (R24)
      end else if (wr_mcu) begin
         sleep_allow  <= io_wdata_i[`CDSC_SA_BIT];
         sleep_select <= io_wdata_i[`CDSC_SS_MSB:`CDSC_SS_LSB];
      end
   end

   //////////////////////////////
   // read port, unmapped offsets read zero

   logic [7:0] next_rdata;
   logic [7:0] mcu_view;

   assign mcu_view = 8'({sleep_allow, sleep_select} << `CDSC_SS_LSB);

   assign next_rdata = sel_div  ? {div_enable, divide_factor} :
                       sel_trim ? osc_trim :
                       sel_mcu  ? mcu_view :
                       8'h00;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata <= 8'h00;
      end else if (io_rd_i) begin
         rdata <= next_rdata;
      end
   end

   assign io_rdata_o = rdata;

   //////////////////////////////
   // divided clock enable

   logic div_tick;

   cdsc_clk_div u_div (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .div_en_i (div_enable),
      .factor_i (divide_factor),
      .tick_o   (div_tick)
   );

   //////////////////////////////
   // mode decode

   cdsc_mode_t mode;
   logic       mode_legal;
   logic       want_sleep;

   // standby codes without a crystal fall back to their base mode
   always_comb begin
      mode       = CDSC_IDLE;
      mode_legal = 1'b1;
      unique case (sleep_select)
         3'b000: mode = CDSC_IDLE; // see (R14)
         3'b001: mode = CDSC_NOISE; // see (R14)
         3'b010: mode = CDSC_PWRDOWN; // see (R14)
         3'b011: mode = CDSC_PWRSAVE; // see (R14)
         3'b110: mode = xtal_selected_i ? CDSC_STANDBY : CDSC_PWRDOWN; // see (R17)
         3'b111: mode = xtal_selected_i ? CDSC_XSTANDBY : CDSC_PWRSAVE; // see (R17)
         default: mode_legal = 1'b0;
      endcase
   end

   assign want_sleep = sleep_instr_i && sleep_allow && mode_legal; // see (R12) (R13)

   //////////////////////////////
   // sleep sequencer

   cdsc_state_t state;
   cdsc_state_t next_state;
   cdsc_mode_t  cur_mode;
   logic [3:0]  wait_cnt;
   logic [3:0]  next_wait_cnt;
   logic [3:0]  startup_len;
   logic        ext_wake;
   logic        wake;

   assign ext_wake = (|edge_irq_low_i) || (|level_irq_high_i) ||
                     two_wire_unit_match_i; // see (R18)

   always_comb begin
      wake = ext_wake;
      unique case (cur_mode)
         CDSC_IDLE:     wake = any_irq_i; // see (R18)
         CDSC_NOISE:    wake = ext_wake || timer0_irq_i || conv_irq_i ||
                               nvm_ready_irq_i; // see (R18)
         CDSC_PWRDOWN:  wake = ext_wake; // see (R18)
         CDSC_STANDBY:  wake = ext_wake; // see (R18)
         CDSC_PWRSAVE,
         CDSC_XSTANDBY: wake = ext_wake ||
                               (timer0_irq_i && timer0_async_select_i); // see (R18)
      endcase
   end

   // oscillator stays up in idle, noise and standby; idle and noise skip the start-up wait
   always_comb begin
      startup_len = 4'h0;
      unique case (cur_mode)
         CDSC_IDLE,
         CDSC_NOISE:    startup_len = 4'h0;
         CDSC_STANDBY,
         CDSC_XSTANDBY: startup_len = `CDSC_STANDBY_CYC; // see (R22)
         CDSC_PWRDOWN,
         CDSC_PWRSAVE:  startup_len = `CDSC_STARTUP_CYC;
      endcase
   end

   always_comb begin
      next_state    = state;
      next_wait_cnt = wait_cnt;
      unique case (state)
         CDSC_ACTIVE: begin
            if (want_sleep) begin
               next_state = CDSC_ASLEEP; // see (R12)
            end
         end
         CDSC_ASLEEP: begin
            if (wake && startup_len != 4'h0) begin
               next_state    = CDSC_STARTUP;
               next_wait_cnt = 4'(startup_len - 4'h1);
            end else if (wake) begin
               next_state    = CDSC_HOLD;
               next_wait_cnt = 4'(`CDSC_HOLD_CYC - 4'h1);
            end
         end
         CDSC_STARTUP: begin
            if (wait_cnt == 4'h0) begin
               next_state    = CDSC_HOLD;
               next_wait_cnt = 4'(`CDSC_HOLD_CYC - 4'h1); // see (R19)
            end else begin
               next_wait_cnt = 4'(wait_cnt - 4'h1); // see (R22)
            end
         end
         CDSC_HOLD: begin
            if (wait_cnt == 4'h0) begin
               next_state = CDSC_ACTIVE; // see (R19)
            end else begin
               next_wait_cnt = 4'(wait_cnt - 4'h1); // see (R19)
            end
         end
      endcase
   end

   // async reset returns straight to active, core restarts at its vector
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state    <= CDSC_ACTIVE; // see (R21)
         wait_cnt <= 4'h0;
      end else begin
         state    <= next_state;
         wait_cnt <= next_wait_cnt;
      end
   end

   // mode latched at entry so a later register write cannot change it
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cur_mode <= CDSC_IDLE;
      end else if (state == CDSC_ACTIVE && want_sleep) begin
         cur_mode <= mode; // see (R13)
      end
   end

   //////////////////////////////
   // domain gating

   logic running;
   logic keep_periph;
   logic keep_conv;
   logic keep_async;
   logic keep_osc;

   assign running  = (state == CDSC_ACTIVE);

   assign keep_periph = (cur_mode == CDSC_IDLE); // see (R15)
   assign keep_conv   = (cur_mode == CDSC_IDLE) || (cur_mode == CDSC_NOISE); // see (R15)
   assign keep_async  = keep_conv ||
                        (((cur_mode == CDSC_PWRSAVE) || (cur_mode == CDSC_XSTANDBY)) &&
                         timer0_async_select_i); // see (R15) (R16)
   assign keep_osc    = (cur_mode != CDSC_PWRDOWN) &&
                        (cur_mode != CDSC_PWRSAVE); // see (R16)

   // only the clocks stop, register file and memory keep power and state
   assign core_clk_en_o   = running && div_tick; // see (R15) (R20)
   assign nvm_clk_en_o    = running && div_tick; // see (R15)
   assign periph_clk_en_o = (running || keep_periph) && div_tick; // see (R1) (R15)
   assign conv_clk_en_o   = (running || keep_conv) && div_tick; // see (R1) (R15)
   assign async_clk_en_o  = running || keep_async; // see (R15)

   // during start-up and hold the oscillator must run again
   assign main_osc_en_o = running || keep_osc || (state != CDSC_ASLEEP); // see (R16)

   //////////////////////////////
   // status

   logic sleeping;
   logic wake_irq;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sleeping <= 1'b0;
         wake_irq <= 1'b0;
      end else begin
         sleeping <= (next_state != CDSC_ACTIVE);
         wake_irq <= (state == CDSC_HOLD) && (next_state == CDSC_ACTIVE);
      end
   end

   // handler runs next, then the instruction after the sleep, see (R19)
   assign sleeping_o = sleeping;
   assign wake_irq_o = wake_irq;

   // the async timer rate limit while divided is left to software

endmodule : cdsc_top

/* inc/cdsc_params.svh */
// constants of the clock divide and sleep control block
// assumes one 40 MHz source clock and 8-bit i/o register accesses
//
// Function
// (R1) divide enable set: core, memory, i/o, converter clocks run divided
// (R2) divided rate is source over (129 minus factor), divisors 2 to 129
// (R3) factor field changes only while divide enable is zero
// (R4) write setting enable captures the factor written with it
// (R5) write clearing enable drops the factor written with it
// (R6) software keeps async timer below quarter divided rate while divided
// (R7) i/o addresses 0x00-0x3F, data space adds 0x20, divider at 0x5C
// (R8) during reset the calibration byte is loaded into the trim register; the code loads it on the first edge after reset release
// (R9) trim value raises oscillator frequency monotonically, 0x00 lowest, 0xFF highest
// (R10) trim 0x00 gives 50-100, 0x7F 75-150, 0xFF 100-200 percent
// (R11) software keeps trim within 10 percent above nominal during memory writes
// (R12) sleep entered only by sleep instruction with sleep allow set
// (R13) three select bits choose among six sleep modes
// (R14) select codes 000,001,010,011,110,111 map to the six modes
// (R15) sleep stops core and memory clocks, others kept per mode
// (R16) main oscillator runs except in power-down and power-save
// (R17) standby modes apply only with external crystal selected
// (R18) deep modes wake only on edge lines, upper level lines, address match; the code also wakes save modes on timer 0 with async selected
// (R19) wake holds the core four cycles beyond start-up
// (R20) register file and data memory kept across sleep
// (R21) reset during sleep wakes the device to the reset vector
// (R22) standby wake-up completes in 6 clock cycles
// (R23) divider settings switch only on a divided clock boundary
// (R24) reset clears divider register, sleep allow and sleep select
`ifndef CDSC_PARAMS_SVH
`define CDSC_PARAMS_SVH

`define CDSC_IO_TOP        8'h3F
`define CDSC_DS_OFFSET     8'h20
`define CDSC_ADDR_TRIM     8'h31
`define CDSC_ADDR_MCUCTL   8'h35
`define CDSC_ADDR_DIV      8'h3C
`define CDSC_DIV_EN_BIT    7
`define CDSC_DIV_BASE      8'h81
`define CDSC_SA_BIT        5
`define CDSC_SS_MSB        4
`define CDSC_SS_LSB        2
`define CDSC_RST_DIV       8'h00
`define CDSC_RST_TRIM      8'h00
`define CDSC_RST_MCUCTL    8'h00
`define CDSC_HOLD_CYC      4'h4
`define CDSC_STANDBY_CYC   4'h6
`define CDSC_STARTUP_CYC   4'h6

`endif

/* inc/cdsc_pkg.sv */
// types of the clock divide and sleep control block
// assumes cdsc_params.svh is on the include path
package cdsc_pkg;

   typedef enum logic [3:0] {
      CDSC_ACTIVE  = 4'b0001,
      CDSC_ASLEEP  = 4'b0010,
      CDSC_STARTUP = 4'b0100,
      CDSC_HOLD    = 4'b1000
   } cdsc_state_t;

   typedef enum logic [2:0] {
      CDSC_IDLE     = 3'b000,
      CDSC_NOISE    = 3'b001,
      CDSC_PWRDOWN  = 3'b010,
      CDSC_PWRSAVE  = 3'b011,
      CDSC_STANDBY  = 3'b110,
      CDSC_XSTANDBY = 3'b111
   } cdsc_mode_t;

endpackage : cdsc_pkg

/* core/cdsc_clk_div.sv */
// divided clock enable generator
// assumes settings are held stable by the caller between writes
`timescale 1ns/1ps
`include "cdsc_params.svh"
module cdsc_clk_div
   import cdsc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       div_en_i,
   input  wire logic [6:0] factor_i,
   output logic            tick_o
);

   logic       act_en;
   logic [6:0] act_factor;
   logic [7:0] count;
   logic [7:0] last_count;
   logic       at_end;

   // divisor 129 - d, counted 0 .. divisor-1
   assign last_count = 8'(`CDSC_DIV_BASE - {1'b0, act_factor} - 8'h01); // see (R2)
   assign at_end     = !act_en || (count == last_count);
   assign tick_o     = at_end; // see (R1)

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count <= 8'h00;
      end else if (at_end) begin
         count <= 8'h00;
      end else begin
         count <= 8'(count + 8'h01);
      end
   end

   // new settings only at the boundary, so no short pulse reaches a domain
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         act_en     <= 1'b0;
         act_factor <= 7'h00;
      end else if (at_end) begin
         act_en     <= div_en_i; // see (R23)
         act_factor <= factor_i; // see (R23)
      end
   end

endmodule : cdsc_clk_div

/* sim/cdsc_monitor.sv */
// assertions on the ports of the clock divide and sleep control block
// assumes one source clock domain; bound onto cdsc_top at the foot
`timescale 1ns/1ps
`include "cdsc_params.svh"
module cdsc_monitor
   import cdsc_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       arst_n_i,
   input wire logic [7:0] io_addr_i,
   input wire logic       io_data_space_i,
   input wire logic       io_wr_i,
   input wire logic       io_rd_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic       sleep_instr_i,
   input wire logic       any_irq_i,
   input wire logic [3:0] edge_irq_low_i,
   input wire logic [3:0] level_irq_high_i,
   input wire logic       two_wire_unit_match_i,
   input wire logic [7:0] trim_value_o,
   input wire logic       core_clk_en_o,
   input wire logic       nvm_clk_en_o,
   input wire logic       periph_clk_en_o,
   input wire logic       conv_clk_en_o,
   input wire logic       async_clk_en_o,
   input wire logic       main_osc_en_o,
   input wire logic       sleeping_o,
   input wire logic       wake_irq_o
);
   //////////////////////////////
   // shadow of the control register, so mode is known without peeking inside
   logic [7:0] ctl;
   logic       first;
   wire  [7:0] ioa = io_data_space_i ? io_addr_i - `CDSC_DS_OFFSET : io_addr_i;
   wire        hit_trim = ioa == `CDSC_ADDR_TRIM;
   wire        mapped = hit_trim || ioa == `CDSC_ADDR_MCUCTL || ioa == `CDSC_ADDR_DIV;
   wire  [2:0] sel = ctl[`CDSC_SS_MSB:`CDSC_SS_LSB];
   wire        legal = ctl[`CDSC_SA_BIT] && sel[2:1] != 2'h2;
   wire        deep_src = |edge_irq_low_i || |level_irq_high_i || two_wire_unit_match_i;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctl   <= `CDSC_RST_MCUCTL;
         first <= 1'b1;
      end else begin
         first <= 1'b0;
         if (io_wr_i && ioa == `CDSC_ADDR_MCUCTL) begin
            ctl <= io_wdata_i;
         end
      end
   end
   //////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_short_wake;
      sleeping_o [*5] ##[1:2] !sleeping_o;
   endsequence
   sequence s_long_wake;
      sleeping_o [*8] ##[2:6] !sleeping_o;
   endsequence
   property p_gate; sleeping_o |-> !core_clk_en_o && !nvm_clk_en_o; endproperty
   a_gate: assert property (p_gate) else $error("core clock ran asleep");
   property p_same; !sleeping_o |-> core_clk_en_o == periph_clk_en_o; endproperty
   a_same: assert property (p_same) else $error("domains not divided alike");
   property p_pd;
      sleeping_o && !deep_src && sel == CDSC_PWRDOWN |->
         !main_osc_en_o && !periph_clk_en_o && !conv_clk_en_o && !async_clk_en_o;
   endproperty
   a_pd: assert property (p_pd) else $error("clock kept in power-down");
   property p_idle; sleeping_o && !any_irq_i && sel == CDSC_IDLE |-> main_osc_en_o; endproperty
   a_idle: assert property (p_idle) else $error("oscillator off in idle");
   property p_refuse; sleep_instr_i && !sleeping_o && !legal |=> !sleeping_o; endproperty
   a_refuse: assert property (p_refuse) else $error("sleep taken unallowed");
   property p_enter; sleep_instr_i && !sleeping_o && legal |=> sleeping_o; endproperty
   a_enter: assert property (p_enter) else $error("sleep not entered");
   property p_short;
      sleeping_o && (sel == CDSC_IDLE && $rose(any_irq_i) ||
                     sel == CDSC_NOISE && $rose(deep_src)) |-> s_short_wake;
   endproperty
   a_short: assert property (p_short) else $error("light wake timing");
   property p_long; sleeping_o && sel[1] && $rose(deep_src) |-> s_long_wake; endproperty
   a_long: assert property (p_long) else $error("deep wake timing");
   property p_irq; $fell(sleeping_o) |-> wake_irq_o ##1 !wake_irq_o; endproperty
   a_irq: assert property (p_irq) else $error("wake pulse missing");
   property p_unmap; io_rd_i && !mapped |=> io_rdata_o == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_trim;
      !first |=> trim_value_o ==
         ($past(io_wr_i && hit_trim) ? $past(io_wdata_i) : $past(trim_value_o));
   endproperty
   a_trim: assert property (p_trim) else $error("trim value wrong");
endmodule : cdsc_monitor

bind cdsc_top cdsc_monitor i_mon (.*);

/* sim/cdsc_domain_model.sv */
// model of the gated peripheral domain and of software's timer setup
// assumes the peripheral enable is sampled on the rising source edge
`timescale 1ns/1ps
module cdsc_domain_model (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       periph_clk_en_i,
   input  wire logic       div_on_i,
   input  wire logic       async_req_i,
   output logic            timer0_async_select_o,
   output logic      [7:0] gap_o
);
   logic [7:0] cnt;
   // while divided, software runs timer 0 from its async clock only
   assign timer0_async_select_o = div_on_i || async_req_i;
   // spacing of domain pulses; wraps in long sleeps, only read while active
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt   <= 8'h01;
         gap_o <= 8'h00;
      end else if (periph_clk_en_i) begin
         gap_o <= cnt;
         cnt   <= 8'h01;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule : cdsc_domain_model

/* sim/tb.sv */
// self-checking bench of the clock divide and sleep control block
// assumes the domain model and the bound monitor are compiled first
`timescale 1ns/1ps
`include "cdsc_params.svh"
module tb
   import cdsc_pkg::*;
();
   logic       clk_i, arst_n_i, io_data_space_i, io_wr_i, io_rd_i, sleep_instr_i;
   logic       xtal_selected_i, any_irq_i, two_wire_unit_match_i, timer0_irq_i;
   logic       conv_irq_i, nvm_ready_irq_i, async_req;
   logic [7:0] io_addr_i, io_wdata_i, cal_byte_i, divr, q, n, cal;
   logic [3:0] edge_irq_low_i, level_irq_high_i;
   wire  [7:0] io_rdata_o, trim_value_o, gap;
   wire        timer0_async_select_i, core_clk_en_o, nvm_clk_en_o, periph_clk_en_o;
   wire        conv_clk_en_o, async_clk_en_o, main_osc_en_o, sleeping_o, wake_irq_o;
   wire  [3:0] en4 = {periph_clk_en_o, conv_clk_en_o, async_clk_en_o, main_osc_en_o};
   int         err_count, num_checks;
   logic [2:0] modes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4, 3'h5};

   cdsc_domain_model i_model (
      .clk_i                (clk_i),
      .arst_n_i             (arst_n_i),
      .periph_clk_en_i      (periph_clk_en_o),
      .div_on_i             (divr[7]),
      .async_req_i          (async_req),
      .timer0_async_select_o(timer0_async_select_i),
      .gap_o                (gap)
   );
   cdsc_top i_dut (.*);

   always #12.5 clk_i = ~clk_i;
   //////////////////////////////
   task automatic stop_test;
      if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // one access; the address form is drawn at random
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      logic ds;
      ds = 1'($urandom);
      @(posedge clk_i);
      io_data_space_i <= ds;
      io_addr_i       <= ds ? a + `CDSC_DS_OFFSET : a;
      io_wdata_i      <= d;
      io_wr_i         <= wr;
      io_rd_i         <= !wr;
      @(posedge clk_i);
      io_wr_i <= 1'b0;
      io_rd_i <= 1'b0;
      #1 q = io_rdata_o;
   endtask : acc
   function automatic logic [7:0] div_next(input logic [7:0] c, input logic [7:0] w);
      if (!w[7]) return {1'b0, c[6:0]};
      if (!c[7]) return w;
      return c;
   endfunction : div_next
   // enables kept per mode: periph, conv, async, oscillator
   function automatic logic [3:0] dom(input logic [2:0] s, input logic as, input logic x);
      case (s)
         CDSC_IDLE:     return 4'hF;
         CDSC_NOISE:    return 4'h7;
         CDSC_PWRSAVE:  return {2'h0, as, 1'b0};
         CDSC_STANDBY:  return {3'h0, x};
         CDSC_XSTANDBY: return {2'h0, as, x};
         default:       return 4'h0;
      endcase
   endfunction : dom
   task automatic wdiv(input logic [7:0] w);
      acc(1'b1, `CDSC_ADDR_DIV, w);
      divr = div_next(divr, w);
      acc(1'b0, `CDSC_ADDR_DIV, 8'h00);
      chk(q, divr);
   endtask : wdiv
   task automatic check_reset;
      #1 chk(trim_value_o, cal);
      acc(1'b0, `CDSC_ADDR_DIV, 8'h00);
      chk(q, `CDSC_RST_DIV);
      acc(1'b0, `CDSC_ADDR_MCUCTL, 8'h00);
      chk(q, `CDSC_RST_MCUCTL);
   endtask : check_reset
   task automatic enter(input logic sa, input logic [2:0] s);
      acc(1'b1, `CDSC_ADDR_MCUCTL, {2'h0, sa, s, 2'h0});
      @(posedge clk_i);
      sleep_instr_i <= 1'b1;
      @(posedge clk_i);
      sleep_instr_i <= 1'b0;
      #1 chk(8'(sleeping_o), 8'(sa && s[2:1] != 2'h2));
   endtask : enter
   task automatic wake(input logic [2:0] s);
      logic [7:0] k;
      k = {4'h0, dom(s, async_req, xtal_selected_i)};
      chk({4'h0, en4}, k);
      if (s[1]) begin
         // timer 0 wakes the save modes, so it only knocks on the others
         {any_irq_i, conv_irq_i, nvm_ready_irq_i} <= 3'h7;
         timer0_irq_i <= !s[0];
         repeat (10) @(posedge clk_i);
         #1 chk(8'(sleeping_o), 8'h01);
         {any_irq_i, timer0_irq_i, conv_irq_i, nvm_ready_irq_i} <= 4'h0;
      end
      k = 8'($urandom % 3);
      @(posedge clk_i);
      if (s == CDSC_IDLE) any_irq_i <= 1'b1;
      else if (k == 0) edge_irq_low_i <= 4'h1 << ($urandom % 4);
      else if (k == 1) level_irq_high_i <= 4'h1 << ($urandom % 4);
      else two_wire_unit_match_i <= 1'b1;
      n = 8'h00;
      while (sleeping_o !== 1'b0) begin
         @(posedge clk_i);
         #1 n++;
         if (n > 40) begin
            err_count++;
            stop_test();
         end
      end
      k = 8'(1 + `CDSC_HOLD_CYC + (s[1] ? `CDSC_STARTUP_CYC : 0));
      chk(n, k);
      chk(8'(wake_irq_o), 8'h01);
      {any_irq_i, two_wire_unit_match_i} <= 2'h0;
      edge_irq_low_i   <= 4'h0;
      level_irq_high_i <= 4'h0;
   endtask : wake
   //////////////////////////////
   initial begin
      #2_500_000;
      err_count++;
      stop_test();
   end
   initial begin
      {clk_i, arst_n_i, io_data_space_i, io_wr_i, io_rd_i, sleep_instr_i} = 6'h00;
      {xtal_selected_i, any_irq_i, two_wire_unit_match_i, timer0_irq_i} = 4'h0;
      {conv_irq_i, nvm_ready_irq_i, async_req} = 3'h0;
      {io_addr_i, io_wdata_i, edge_irq_low_i, level_irq_high_i} = 24'h00_0000;
      divr = 8'h00;
      cal = 8'($urandom(32'h374f_734b));
      cal_byte_i = cal;
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check_reset();
      // no memory write runs while the trim is swept
      for (int i = 0; i < 10; i++) begin
         n = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom);
         acc(1'b1, `CDSC_ADDR_TRIM, n);
         chk(trim_value_o, n);
         acc(1'b0, `CDSC_ADDR_TRIM, 8'h00);
         chk(q, n);
      end
      acc(1'b1, 8'h32, 8'hA5);
      acc(1'b0, 8'h32, 8'h00);
      chk(q, 8'h00);
      // fastest, slowest and one random divisor; only late gaps are judged
      for (int i = 0; i < 3; i++) begin
         n = i == 0 ? 8'h7F : i == 1 ? 8'h00 : 8'($urandom) & 8'h7F;
         wdiv(8'h80 | n);
         wdiv(~n);
         repeat (387) @(posedge clk_i);
         #1 chk(gap, `CDSC_DIV_BASE - n);
         wdiv(~n & 8'h7F);
         repeat (131) @(posedge clk_i);
         #1 chk(gap, 8'h01);
      end
      enter(1'b0, CDSC_PWRDOWN);
      for (int i = 0; i < 8; i++) begin
         async_req       <= 1'($urandom);
         xtal_selected_i <= 1'($urandom);
         enter(1'b1, modes[i]);
         if (sleeping_o === 1'b1) wake(modes[i]);
      end
      enter(1'b1, CDSC_PWRDOWN);
      repeat (3) @(posedge clk_i);
      cal = 8'($urandom);
      cal_byte_i <= cal;
      arst_n_i   <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 chk(8'(sleeping_o), 8'h00);
      arst_n_i <= 1'b1;
      divr = 8'h00;
      repeat (2) @(posedge clk_i);
      check_reset();
      stop_test();
   end
endmodule : tb
